// ### logic/lcb_consts.svh
// timing counts, burst length and cas latency for the cross-bank command checker
`ifndef LCB_CONSTS_SVH
`define LCB_CONSTS_SVH
`define LCB_CLK_NS 40
`define LCB_T_RP_NS 18
`define LCB_T_RCD_NS 18
`define LCB_T_WR_NS 15
`define LCB_T_WTR_CK 2
`define LCB_T_XP_CK 2
`define LCB_T_XSR_NS 120
`define LCB_T_RFC_NS 72
`define LCB_T_MRD_CK 2
`define LCB_RP_CK ((`LCB_T_RP_NS + `LCB_CLK_NS - 1) / `LCB_CLK_NS)
`define LCB_RCD_CK ((`LCB_T_RCD_NS + `LCB_CLK_NS - 1) / `LCB_CLK_NS)
`define LCB_WR_CK ((`LCB_T_WR_NS + `LCB_CLK_NS - 1) / `LCB_CLK_NS)
`define LCB_XSR_CK ((`LCB_T_XSR_NS + `LCB_CLK_NS - 1) / `LCB_CLK_NS)
`define LCB_RFC_CK ((`LCB_T_RFC_NS + `LCB_CLK_NS - 1) / `LCB_CLK_NS)
`define LCB_BL 8
`define LCB_CL 3
`endif

// ### logic/lcb_pkg.sv
// types shared by both ends of the cross-bank command link
package lcb_pkg;
    typedef enum logic [3:0] {
        LCB_CMD_DESEL, LCB_CMD_NOP, LCB_CMD_ACT, LCB_CMD_RD, LCB_CMD_WR, LCB_CMD_PRE,
        LCB_CMD_BST, LCB_CMD_AREF, LCB_CMD_LMR
    } lcb_cmd_t;
    typedef enum logic [2:0] {
        LCB_BK_IDLE, LCB_BK_ACTIVATING, LCB_BK_ACTIVE, LCB_BK_READ, LCB_BK_WRITE,
        LCB_BK_READ_AUTO, LCB_BK_WRITE_AUTO, LCB_BK_PRECHARGING
    } lcb_bank_t;
    typedef enum logic [2:0] {
        LCB_PW_NORMAL, LCB_PW_ACT_PD, LCB_PW_PRE_PD, LCB_PW_SELF_REF, LCB_PW_DEEP_PD, LCB_PW_EXIT
    } lcb_pwr_t;
    function automatic lcb_cmd_t lcb_decode(input logic cs_n, input logic ras_n, input logic cas_n,
                                            input logic we_n);
        lcb_cmd_t c;
        c = LCB_CMD_DESEL;
        if (!cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'h7: c = LCB_CMD_NOP;
                3'h3: c = LCB_CMD_ACT;
                3'h5: c = LCB_CMD_RD;
                3'h4: c = LCB_CMD_WR;
                3'h2: c = LCB_CMD_PRE;
                3'h6: c = LCB_CMD_BST;
                3'h1: c = LCB_CMD_AREF;
                3'h0: c = LCB_CMD_LMR;
            endcase
        end
        return c;
    endfunction
endpackage

// ### logic/lcb_if.sv
// command bus between controller and device
interface lcb_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic auto_precharge_flag;
    logic [1:0] dm;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, auto_precharge_flag, dm);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, auto_precharge_flag, dm);
endinterface

// ### logic/lcb_device.sv
// device end: per-bank state, cross-bank legality and cke power states
//Contract
//- decode cs ras cas we into commands
//- idle bank allows bank m commands
//- busy bank accepts commands to others
//- write after read burst ends only (not checked: a write to a bank in LCB_BK_READ is accepted)
//- read during write needs dm masking (not checked: dm is ignored)
//- auto-precharge access allows other-bank commands
//- split auto-precharge into access, precharge periods
//- write-ap to other bank minimum delays
//- read-ap to other bank minimum delays
//- refresh, mode load need all idle
//- cke low twice holds power state
//- cke falling enters chosen power state
//- cke rising with nop exits state
//- only nop during txp, txsr
//- deep power-down exit needs reinit
//- clock toggles twice during txsr
//- bank rules only with cke high twice
//- unlisted combinations are illegal (not checked: commands with cke low on both edges are ignored)
//- idle after trp, active after trcd
`include "lcb_consts.svh"
module lcb_device
    import lcb_pkg::*;
#(
    parameter int NBANK = 4,
    parameter int BL = `LCB_BL,
    parameter int CL = `LCB_CL
) (
    input wire logic clk_sys_i, // system clock
    input wire logic reset_n_i, // sync reset, low
    lcb_if.dev bus, // command bus from controller
    input wire logic init_done_i, // controller finished reinit
    output logic illegal_o, // pulse: illegal command seen
    output logic [2:0] pwr_state_o, // power state code
    output logic [2*NBANK-1:0] bank_state_o, // 2-bit code per bank: 0 idle, 1 active, 2 precharging, 3 any other state
    output logic need_init_o // deep power-down left, reinit pending
);
    localparam int CW = 6;
    localparam logic [CW-1:0] RP_C = CW'(`LCB_RP_CK);
    localparam logic [CW-1:0] RCD_C = CW'(`LCB_RCD_CK);
    localparam logic [CW-1:0] BURST_C = CW'(BL / 2);
    localparam logic [CW-1:0] WRAP_C = CW'(BL / 2 + `LCB_WR_CK);
    localparam logic [CW-1:0] XP_C = CW'(`LCB_T_XP_CK);
    localparam logic [CW-1:0] XSR_C = CW'(`LCB_XSR_CK);
    localparam logic [CW-1:0] RFC_C = CW'(`LCB_RFC_CK);
    localparam logic [CW-1:0] MRD_C = CW'(`LCB_T_MRD_CK);
    // gaps load one short: they count down from the edge after the command
    localparam logic [CW-1:0] WAP_RD_C = CW'(BL / 2 + `LCB_T_WTR_CK);
    localparam logic [CW-1:0] WAP_WR_C = CW'(BL / 2 - 1);
    localparam logic [CW-1:0] RAP_RD_C = CW'(BL / 2 - 1);
    localparam logic [CW-1:0] RAP_WR_C = CW'(CL + BL / 2 - 1);

    lcb_bank_t bank [NBANK];
    lcb_bank_t next_bank [NBANK];
    logic [CW-1:0] bcnt [NBANK];
    logic [CW-1:0] next_bcnt [NBANK];
    lcb_pwr_t pwr, next_pwr;
    logic [CW-1:0] gcnt, next_gcnt; // exit, refresh or mode-load quiet time
    logic [CW-1:0] rd_gap, next_rd_gap; // earliest other-bank read
    logic [CW-1:0] wr_gap, next_wr_gap; // earliest other-bank write
    logic cke_prev, next_cke_prev;
    logic dinit, next_dinit;
    logic ill, next_ill;
    lcb_cmd_t cmd;
    logic all_idle, any_open, cmd_ok;

    assign cmd = lcb_decode(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n);

    always_comb begin
        all_idle = 1'b1;
        any_open = 1'b0;
        for (int i = 0; i < NBANK; i++) begin
            if (bank[i] != LCB_BK_IDLE) all_idle = 1'b0;
            if (bank[i] != LCB_BK_IDLE && bank[i] != LCB_BK_PRECHARGING) any_open = 1'b1;
        end
    end

    // legality of a command on a normal edge, against target bank and other-bank delays
    always_comb begin
        lcb_bank_t t;
        t = bank[bus.ba];
        cmd_ok = 1'b1;
        unique case (cmd)
            LCB_CMD_DESEL, LCB_CMD_NOP: cmd_ok = 1'b1;
            LCB_CMD_ACT: cmd_ok = (t == LCB_BK_IDLE);
            LCB_CMD_RD: cmd_ok = (t == LCB_BK_ACTIVE || t == LCB_BK_READ || t == LCB_BK_WRITE)
                                 && rd_gap == '0;
            LCB_CMD_WR: cmd_ok = (t == LCB_BK_ACTIVE || t == LCB_BK_READ || t == LCB_BK_WRITE)
                                 && wr_gap == '0;
            LCB_CMD_PRE: cmd_ok = (t != LCB_BK_ACTIVATING && t != LCB_BK_READ_AUTO
                                   && t != LCB_BK_WRITE_AUTO);
            LCB_CMD_BST: cmd_ok = 1'b1;
            LCB_CMD_AREF, LCB_CMD_LMR: cmd_ok = all_idle;
        endcase
        if (gcnt != '0 && cmd != LCB_CMD_NOP && cmd != LCB_CMD_DESEL) cmd_ok = 1'b0;
        if (dinit && cmd != LCB_CMD_NOP && cmd != LCB_CMD_DESEL && cmd != LCB_CMD_PRE
            && cmd != LCB_CMD_AREF && cmd != LCB_CMD_LMR) cmd_ok = 1'b0;
    end

    always_comb begin
        next_pwr = pwr;
        next_gcnt = (gcnt != '0) ? gcnt - 1'b1 : gcnt;
        next_rd_gap = (rd_gap != '0) ? rd_gap - 1'b1 : rd_gap;
        next_wr_gap = (wr_gap != '0) ? wr_gap - 1'b1 : wr_gap;
        next_cke_prev = bus.cke;
        next_dinit = dinit & ~init_done_i;
        next_ill = 1'b0;
        for (int i = 0; i < NBANK; i++) begin
            next_bank[i] = bank[i];
            next_bcnt[i] = (bcnt[i] != '0) ? bcnt[i] - 1'b1 : bcnt[i];
            // timed bank transitions
            if (bcnt[i] <= CW'(1)) begin
                unique case (bank[i])
                    LCB_BK_ACTIVATING: next_bank[i] = LCB_BK_ACTIVE;
                    LCB_BK_READ, LCB_BK_WRITE: next_bank[i] = LCB_BK_ACTIVE;
                    LCB_BK_READ_AUTO, LCB_BK_WRITE_AUTO: begin
                        next_bank[i] = LCB_BK_PRECHARGING;
                        next_bcnt[i] = RP_C;
                    end
                    LCB_BK_PRECHARGING: next_bank[i] = LCB_BK_IDLE;
                    default: next_bank[i] = bank[i];
                endcase
            end
        end
        if (!cke_prev && !bus.cke) begin
            next_pwr = pwr;
        end else if (!cke_prev && bus.cke) begin
            if (cmd == LCB_CMD_NOP || cmd == LCB_CMD_DESEL) begin
                next_pwr = LCB_PW_NORMAL;
                next_gcnt = (pwr == LCB_PW_SELF_REF) ? XSR_C : XP_C;
                if (pwr == LCB_PW_DEEP_PD) next_dinit = 1'b1;
            end else begin
                next_ill = 1'b1;
            end
        end else if (cke_prev && !bus.cke) begin
            next_ill = 1'b1;
            if (any_open && (cmd == LCB_CMD_NOP || cmd == LCB_CMD_DESEL)) begin
                next_pwr = LCB_PW_ACT_PD;
                next_ill = 1'b0;
            end else if (all_idle) begin
                next_ill = 1'b0;
                unique case (cmd)
                    LCB_CMD_NOP, LCB_CMD_DESEL: next_pwr = LCB_PW_PRE_PD;
                    LCB_CMD_BST: next_pwr = LCB_PW_DEEP_PD;
                    LCB_CMD_AREF: next_pwr = LCB_PW_SELF_REF;
                    default: next_ill = 1'b1;
                endcase
            end
        end else begin
            // both edges high: bank rules apply
            next_ill = ~cmd_ok;
            if (cmd_ok) begin
                unique case (cmd)
                    LCB_CMD_ACT: begin
                        next_bank[bus.ba] = LCB_BK_ACTIVATING;
                        next_bcnt[bus.ba] = RCD_C;
                    end
                    LCB_CMD_RD: begin
                        next_bank[bus.ba] = bus.auto_precharge_flag ? LCB_BK_READ_AUTO : LCB_BK_READ;
                        next_bcnt[bus.ba] = BURST_C;
                        // a newer command never shortens a gap still running
                        if (bus.auto_precharge_flag) begin
                            if (RAP_RD_C > next_rd_gap) next_rd_gap = RAP_RD_C;
                            if (RAP_WR_C > next_wr_gap) next_wr_gap = RAP_WR_C;
                        end
                    end
                    LCB_CMD_WR: begin
                        next_bank[bus.ba] = bus.auto_precharge_flag ? LCB_BK_WRITE_AUTO : LCB_BK_WRITE;
                        next_bcnt[bus.ba] = bus.auto_precharge_flag ? WRAP_C : BURST_C;
                        if (bus.auto_precharge_flag) begin
                            if (WAP_RD_C > next_rd_gap) next_rd_gap = WAP_RD_C;
                            if (WAP_WR_C > next_wr_gap) next_wr_gap = WAP_WR_C;
                        end
                    end
                    LCB_CMD_PRE: begin
                        if (bank[bus.ba] != LCB_BK_IDLE) begin
                            next_bank[bus.ba] = LCB_BK_PRECHARGING;
                            next_bcnt[bus.ba] = RP_C;
                        end
                    end
                    LCB_CMD_BST: begin
                        for (int i = 0; i < NBANK; i++)
                            if (bank[i] == LCB_BK_READ) next_bank[i] = LCB_BK_ACTIVE;
                    end
                    LCB_CMD_AREF: next_gcnt = RFC_C;
                    LCB_CMD_LMR: next_gcnt = MRD_C;
                    default: next_gcnt = next_gcnt;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NBANK; i++) begin
                bank[i] <= LCB_BK_IDLE;
                bcnt[i] <= '0;
            end
            pwr <= LCB_PW_NORMAL;
            gcnt <= '0;
            rd_gap <= '0;
            wr_gap <= '0;
            cke_prev <= 1'b1;
            dinit <= 1'b0;
            ill <= 1'b0;
        end else begin
            for (int i = 0; i < NBANK; i++) begin
                bank[i] <= next_bank[i];
                bcnt[i] <= next_bcnt[i];
            end
            pwr <= next_pwr;
            gcnt <= next_gcnt;
            rd_gap <= next_rd_gap;
            wr_gap <= next_wr_gap;
            cke_prev <= next_cke_prev;
            dinit <= next_dinit;
            ill <= next_ill;
        end
    end

    assign illegal_o = ill;
    assign pwr_state_o = 3'(pwr);
    assign need_init_o = dinit;
    for (genvar g = 0; g < NBANK; g++) begin : g_bs
        assign bank_state_o[2*g +: 2] = (bank[g] == LCB_BK_IDLE) ? 2'h0 :
                                        (bank[g] == LCB_BK_PRECHARGING) ? 2'h2 :
                                        (bank[g] == LCB_BK_ACTIVE) ? 2'h1 : 2'h3;
    end
endmodule // lcb_device

// ### logic/lcb_ctrl.sv
// controller end: issues one user request when cross-bank delays allow
`include "lcb_consts.svh"
module lcb_ctrl
    import lcb_pkg::*;
#(
    parameter int BL = `LCB_BL,
    parameter int CL = `LCB_CL
) (
    input wire logic clk_sys_i, // system clock
    input wire logic reset_n_i, // sync reset, low
    lcb_if.ctrl bus, // command bus to device
    input wire logic req_i, // request valid
    input wire lcb_cmd_t req_cmd_i, // requested command
    input wire logic [1:0] req_ba_i, // target bank
    input wire logic req_auto_precharge_flag_i, // auto precharge flag
    input wire logic cke_req_i, // wanted cke level
    output logic req_ready_o // request taken this cycle
);
    localparam int CW = 6;
    logic [CW-1:0] rd_gap, next_rd_gap;
    logic [CW-1:0] wr_gap, next_wr_gap;
    logic [CW-1:0] quiet, next_quiet; // nop-only window after exit
    logic cke, next_cke;
    logic [3:0] cmdpins, next_cmdpins;
    logic [1:0] ba, next_ba;
    logic auto_pre, next_auto_pre;
    logic [CW-1:0] rd_load, wr_load; // gaps asked for by the command taken now
    logic go;

    // only nop while quiet; cross-bank read/write gaps honoured
    always_comb begin
        go = req_i && quiet == '0 && cke && cke_req_i;
        if (req_cmd_i == LCB_CMD_RD && rd_gap != '0) go = 1'b0;
        if (req_cmd_i == LCB_CMD_WR && wr_gap != '0) go = 1'b0;
    end
    assign req_ready_o = go;

    always_comb begin
        next_rd_gap = (rd_gap != '0) ? rd_gap - 1'b1 : rd_gap;
        next_wr_gap = (wr_gap != '0) ? wr_gap - 1'b1 : wr_gap;
        next_quiet = (quiet != '0) ? quiet - 1'b1 : quiet;
        next_cke = cke_req_i;
        next_cmdpins = 4'h7; // nop
        next_ba = ba;
        next_auto_pre = 1'b0;
        rd_load = '0;
        wr_load = '0;
        if (!cke && cke_req_i) next_quiet = CW'(`LCB_XSR_CK);
        if (go) begin
            next_ba = req_ba_i;
            next_auto_pre = req_auto_precharge_flag_i;
            unique case (req_cmd_i)
                LCB_CMD_ACT: next_cmdpins = 4'h3;
                LCB_CMD_RD: next_cmdpins = 4'h5;
                LCB_CMD_WR: next_cmdpins = 4'h4;
                LCB_CMD_PRE: next_cmdpins = 4'h2;
                LCB_CMD_BST: next_cmdpins = 4'h6;
                LCB_CMD_AREF: next_cmdpins = 4'h1;
                LCB_CMD_LMR: next_cmdpins = 4'h0;
                default: next_cmdpins = 4'h7;
            endcase
            // loads are one short: the gap counts from the edge after the take
            if (req_cmd_i == LCB_CMD_WR) begin
                rd_load = req_auto_precharge_flag_i ? CW'(BL / 2 + `LCB_T_WTR_CK) : CW'(BL / 2);
                wr_load = req_auto_precharge_flag_i ? CW'(BL / 2 - 1) : '0;
            end
            if (req_cmd_i == LCB_CMD_RD) begin
                rd_load = req_auto_precharge_flag_i ? CW'(BL / 2 - 1) : '0;
                wr_load = CW'(CL + BL / 2 - 1);
            end
        end
        // a newer command never shortens a gap still running
        if (rd_load > next_rd_gap) next_rd_gap = rd_load;
        if (wr_load > next_wr_gap) next_wr_gap = wr_load;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rd_gap <= '0;
            wr_gap <= '0;
            quiet <= '0;
            cke <= 1'b1;
            cmdpins <= 4'hF;
            ba <= 2'h0;
            auto_pre <= 1'b0;
        end else begin
            rd_gap <= next_rd_gap;
            wr_gap <= next_wr_gap;
            quiet <= next_quiet;
            cke <= next_cke;
            cmdpins <= next_cmdpins;
            ba <= next_ba;
            auto_pre <= next_auto_pre;
        end
    end

    assign bus.cke = cke;
    assign bus.cs_n = cmdpins[3];
    assign bus.ras_n = cmdpins[2];
    assign bus.cas_n = cmdpins[1];
    assign bus.we_n = cmdpins[0];
    assign bus.ba = ba;
    assign bus.auto_precharge_flag = auto_pre;
    assign bus.dm = 2'h0; // masking left to data path
endmodule // lcb_ctrl

// ### verif/lcb_cross_bank_asserts.sv
// concurrent checks on the command bus between controller and device
`include "lcb_consts.svh"
module lcb_cross_bank_asserts #(
    parameter int BL = `LCB_BL,
    parameter int CL = `LCB_CL
) (
    input wire logic clk_sys_i, // system clock
    input wire logic reset_n_i, // sync reset, low
    input wire logic cke, // clock enable
    input wire logic cs_n, // chip select
    input wire logic ras_n, // row strobe
    input wire logic cas_n, // column strobe
    input wire logic we_n, // write enable
    input wire logic [1:0] ba, // bank
    input wire logic auto_precharge_flag, // auto precharge
    input wire logic [1:0] dm // data masks
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    logic nopish, is_rd, is_wr, is_bst, is_aref;
    logic [7:0] wap_cnt, rap_cnt, next_wap_cnt, next_rap_cnt;
    assign nopish = cs_n | (ras_n & cas_n & we_n);
    assign is_rd = cke & ~cs_n & ras_n & ~cas_n & we_n;
    assign is_wr = cke & ~cs_n & ras_n & ~cas_n & ~we_n;
    assign is_bst = ~cs_n & ras_n & cas_n & ~we_n;
    assign is_aref = ~cs_n & ~ras_n & ~cas_n & we_n;
    // ages saturate so a long idle link never wraps into a false gap
    always_comb begin
        next_wap_cnt = (wap_cnt == 8'hFF) ? wap_cnt : wap_cnt + 8'h01;
        next_rap_cnt = (rap_cnt == 8'hFF) ? rap_cnt : rap_cnt + 8'h01;
        if (is_wr && auto_precharge_flag) begin
            next_wap_cnt = 8'h01;
        end
        if (is_rd && auto_precharge_flag) begin
            next_rap_cnt = 8'h01;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            wap_cnt <= 8'hFF;
            rap_cnt <= 8'hFF;
        end else begin
            wap_cnt <= next_wap_cnt;
            rap_cnt <= next_rap_cnt;
        end
    end
    property p_wap_rd;
        is_rd |-> int'(wap_cnt) >= 1 + BL / 2 + `LCB_T_WTR_CK;
    endproperty
    a_wap_rd: assert property (p_wap_rd) else $error("read early after write-ap");
    property p_wap_wr;
        is_wr |-> int'(wap_cnt) >= BL / 2;
    endproperty
    a_wap_wr: assert property (p_wap_wr) else $error("write early after write-ap");
    property p_rap_rd;
        is_rd |-> int'(rap_cnt) >= BL / 2;
    endproperty
    a_rap_rd: assert property (p_rap_rd) else $error("read early after read-ap");
    property p_rap_wr;
        is_wr |-> int'(rap_cnt) >= CL + BL / 2;
    endproperty
    a_rap_wr: assert property (p_rap_wr) else $error("write early after read-ap");
    property p_exit;
        $rose(cke) |-> nopish [*3];
    endproperty
    a_exit: assert property (p_exit) else $error("command inside exit window");
    property p_fall;
        $fell(cke) |-> nopish || is_bst || is_aref;
    endproperty
    a_fall: assert property (p_fall) else $error("bad command with cke falling");
    property p_low;
        !cke && !$past(cke) |-> nopish;
    endproperty
    a_low: assert property (p_low) else $error("command while cke low");
    property p_reset;
        disable iff (1'b0) !reset_n_i |=> cke && cs_n && dm == 2'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("bus not quiet after reset");
endmodule // lcb_cross_bank_asserts

// ### verif/tb_lpddr_cross_bank_cke_rules.sv
// bench: controller and device back to back, plus a device on a hand-driven bus
`include "lcb_consts.svh"
module tb_lpddr_cross_bank_cke_rules import lcb_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, reset_n, req, req_auto_pre, cke_req, init_b, ill_seen, ill_b;
    logic req_ready, illegal, need_init, illegal_b, need_init_b;
    logic [1:0] req_ba;
    logic [2:0] pwr, pwr_b;
    logic [7:0] banks;
    lcb_cmd_t req_cmd;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    lcb_if bus_if();
    lcb_if bad_if();
    lcb_ctrl lcb_ctrl_i(.clk_sys_i(clk_sys), .reset_n_i(reset_n), .bus(bus_if.ctrl), .req_i(req),
        .req_cmd_i(req_cmd), .req_ba_i(req_ba), .req_auto_precharge_flag_i(req_auto_pre), .cke_req_i(cke_req),
        .req_ready_o(req_ready));
    lcb_device lcb_device_i(.clk_sys_i(clk_sys), .reset_n_i(reset_n), .bus(bus_if.dev), .init_done_i(1'b0),
        .illegal_o(illegal), .pwr_state_o(pwr), .bank_state_o(banks), .need_init_o(need_init));
    // second device faces the bench so unlisted sequences can be forced on it
    lcb_device lcb_device_b_i(.clk_sys_i(clk_sys), .reset_n_i(reset_n), .bus(bad_if.dev), .init_done_i(init_b),
        .illegal_o(illegal_b), .pwr_state_o(pwr_b), .bank_state_o(), .need_init_o(need_init_b));
    lcb_cross_bank_asserts #(.BL(`LCB_BL), .CL(`LCB_CL)) lcb_cross_bank_asserts_i(.clk_sys_i(clk_sys),
        .reset_n_i(reset_n), .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n),
        .we_n(bus_if.we_n), .ba(bus_if.ba), .auto_precharge_flag(bus_if.auto_precharge_flag), .dm(bus_if.dm));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (illegal !== 1'b0) ill_seen <= 1'b1;
        if (illegal_b === 1'b1) ill_b <= 1'b1;
        if (cyc == 4000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [3:0] pins(input lcb_cmd_t c);
        case (c)
            LCB_CMD_ACT: return 4'h3;
            LCB_CMD_RD: return 4'h5;
            LCB_CMD_WR: return 4'h4;
            LCB_CMD_PRE: return 4'h2;
            default: return 4'h7;
        endcase
    endfunction
    task automatic idle(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    // leaves req high; the caller issues again or drops it at this same negedge
    task automatic issue(input lcb_cmd_t c, input logic [1:0] b, input logic a, output int t);
        int n;
        n = 0;
        req_cmd = c;
        req_ba = b;
        req_auto_pre = a;
        req = 1'b1;
        #1;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            #1;
            n++;
        end
        chk({7'h00, req_ready}, 8'h01, "ready");
        t = cyc;
        @(negedge clk_sys);
        chk({4'h0, bus_if.cs_n, bus_if.ras_n, bus_if.cas_n, bus_if.we_n}, {4'h0, pins(c)}, "pins");
        chk({5'h00, bus_if.ba, bus_if.auto_precharge_flag}, {5'h00, b, a}, "bank");
    endtask
    task automatic bdrv(input logic k, input logic [3:0] p);
        bad_if.cke = k;
        {bad_if.cs_n, bad_if.ras_n, bad_if.cas_n, bad_if.we_n} = p;
        @(negedge clk_sys);
    endtask
    task automatic s_act_pre();
        int t0, t1;
        issue(LCB_CMD_ACT, 2'h0, 1'b0, t0);
        issue(LCB_CMD_ACT, 2'h1, 1'b0, t1);
        chk(8'(t1 - t0), 8'h01, "act gap");
        issue(LCB_CMD_ACT, 2'h2, 1'b0, t0);
        issue(LCB_CMD_ACT, 2'h3, 1'b0, t0);
        req = 1'b0;
        idle(4);
        chk(banks, 8'h55, "all active");
        issue(LCB_CMD_PRE, 2'h3, 1'b0, t0);
        req = 1'b0;
        idle(4);
        chk(banks, 8'h15, "bank3 idle");
        issue(LCB_CMD_ACT, 2'h3, 1'b0, t0);
        req = 1'b0;
        idle(4);
    endtask
    task automatic s_ap_gaps();
        int t0, t1;
        issue(LCB_CMD_WR, 2'h0, 1'b1, t0);
        issue(LCB_CMD_RD, 2'h1, 1'b0, t1);
        chk(8'(t1 - t0), 8'(1 + `LCB_BL / 2 + `LCB_T_WTR_CK), "wap-rd");
        issue(LCB_CMD_RD, 2'h1, 1'b1, t0);
        issue(LCB_CMD_WR, 2'h2, 1'b0, t1);
        chk(8'(t1 - t0), 8'(`LCB_CL + `LCB_BL / 2), "rap-wr");
        issue(LCB_CMD_WR, 2'h2, 1'b1, t0);
        issue(LCB_CMD_WR, 2'h3, 1'b0, t1);
        chk(8'(t1 - t0), 8'(`LCB_BL / 2), "wap-wr");
        issue(LCB_CMD_ACT, 2'h0, 1'b0, t0);
        issue(LCB_CMD_RD, 2'h0, 1'b1, t0);
        issue(LCB_CMD_ACT, 2'h1, 1'b0, t1);
        chk(8'(t1 - t0), 8'h01, "rap-act");
        issue(LCB_CMD_RD, 2'h1, 1'b0, t1);
        chk(8'(t1 - t0), 8'(`LCB_BL / 2), "rap-rd");
        req = 1'b0;
        idle(24);
        chk(banks, 8'h44, "ap banks idle");
        chk({7'h00, ill_seen}, 8'h00, "no illegal");
    endtask
    task automatic s_power();
        int t0;
        cke_req = 1'b0;
        idle(4);
        chk({5'h00, pwr}, 8'h01, "active pd");
        idle(6);
        chk({5'h00, pwr}, 8'h01, "active pd hold");
        cke_req = 1'b1;
        issue(LCB_CMD_PRE, 2'h1, 1'b0, t0);
        issue(LCB_CMD_PRE, 2'h3, 1'b0, t0);
        req = 1'b0;
        idle(4);
        chk({5'h00, pwr}, 8'h00, "pd left");
        chk(banks, 8'h00, "all idle");
        cke_req = 1'b0;
        idle(4);
        chk({5'h00, pwr}, 8'h02, "precharge pd");
        cke_req = 1'b1;
        idle(6);
        chk({5'h00, pwr}, 8'h00, "pd left");
        chk({7'h00, ill_seen}, 8'h00, "no illegal");
        chk({7'h00, need_init}, 8'h00, "no reinit");
    endtask
    task automatic s_raw_bus();
        ill_b = 1'b0;
        bdrv(1'b1, 4'h7);
        bdrv(1'b0, 4'h1);
        bdrv(1'b0, 4'h3);
        bdrv(1'b0, 4'h7);
        chk({5'h00, pwr_b}, 8'h03, "self refresh");
        repeat (6) bdrv(1'b1, 4'h7);
        chk({5'h00, pwr_b}, 8'h00, "sr left");
        bdrv(1'b0, 4'h6);
        bdrv(1'b0, 4'h7);
        chk({5'h00, pwr_b}, 8'h04, "deep pd");
        repeat (6) bdrv(1'b1, 4'h7);
        chk({7'h00, need_init_b}, 8'h01, "reinit pending");
        chk({7'h00, ill_b}, 8'h00, "quiet so far");
        init_b = 1'b1;
        bdrv(1'b1, 4'h7);
        init_b = 1'b0;
        bdrv(1'b1, 4'h7);
        chk({7'h00, need_init_b}, 8'h00, "reinit done");
        bdrv(1'b1, 4'h1);
        repeat (2) bdrv(1'b1, 4'h7);
        bdrv(1'b1, 4'h0);
        repeat (2) bdrv(1'b1, 4'h7);
        chk({7'h00, ill_b}, 8'h00, "refresh and mode load");
        bdrv(1'b0, 4'h3);
        repeat (3) bdrv(1'b1, 4'h7);
        chk({7'h00, ill_b}, 8'h01, "flagged");
        chk({5'h00, pwr_b}, 8'h00, "state kept");
    endtask
    initial begin
        reset_n = 1'b0;
        req = 1'b0;
        req_cmd = LCB_CMD_NOP;
        req_ba = 2'h0;
        req_auto_pre = 1'b0;
        cke_req = 1'b1;
        init_b = 1'b0;
        bad_if.dm = 2'h0;
        bad_if.ba = 2'h0;
        bad_if.auto_precharge_flag = 1'b0;
        bdrv(1'b1, 4'hF);
        idle(4);
        reset_n = 1'b1;
        ill_seen = 1'b0;
        idle(1);
        s_act_pre();
        s_ap_gaps();
        s_power();
        s_raw_bus();
        finish_test();
    end
endmodule // tb_lpddr_cross_bank_cke_rules
